// ### hw/aca_pkg.sv
// Behaviour
// R1 - missing measuring unit shows not-connected error; reattach and power-up restarts from zero
// R2 - position step beyond response speed latches overspeed indication until reset
// R3 - value beyond display range puts F in the top digit
// R4 - momentary supply dip during measurement latches power-failure indication until reset
// R5 - corrupted stored data shows error with hex code 1 to F
// R6 - no reference-point signal from unit shows reference-point error
// R7 - reset at power-on starts counting, waiting for reference if calibrated
// R8 - reset on counting axis zeroes incremental and peak, keeps absolute
// R9 - reset on error axis zeroes all values, then waits reference if calibrated
// R10 - start restarts peak tracking during count display, ignored at power-on or error
// R11 - absolute/incremental switch ignored in power-on waiting state
// R12 - datum key at power-on shows version; any key returns to waiting
// R13 - latched alarms clear only by reset, each axis independently
package aca_pkg;
	localparam int ACA_POS_W = 24;
	localparam logic [23:0] ACA_RESET_VAL = 24'h000000;
	localparam logic [23:0] ACA_DISP_MAX = 24'h0F423F;
	localparam logic [23:0] ACA_MAX_STEP = 24'h000010;
	localparam int ACA_REF_TIMEOUT = 4096;
	localparam logic [3:0] ACA_OVF_DIGIT = 4'hF;
	localparam logic [3:0] ACA_CODE_NONE = 4'h0;

	typedef enum logic [2:0] {
		ACA_ST_POWERON,
		ACA_ST_VERSION,
		ACA_ST_WAITREF,
		ACA_ST_COUNT,
		ACA_ST_ERROR
	} aca_state_t;

	typedef struct packed {
		logic unit_present;
		logic pos_valid;
		logic [23:0] pos_step;
		logic step_neg;
		logic ref_pulse;
	} aca_axis_in_t;

	typedef struct packed {
		logic not_connected;
		logic overspeed_indication;
		logic overflow_digit;
		logic power_fail;
		logic ref_error;
		logic show_abs;
		logic waiting_ref;
		logic [23:0] incremental_value;
		logic [23:0] absolute_value;
		logic [23:0] peak_value;
	} aca_axis_out_t;

	typedef struct packed {
		logic reset_cmd;
		logic start_cmd;
		logic absinc_cmd;
		logic datum_key;
		logic any_key;
	} aca_keys_t;
endpackage : aca_pkg

// ### hw/aca_axis.sv
`timescale 1ns/1ps
module aca_axis import aca_pkg::*; #(
	parameter int REF_TIMEOUT = ACA_REF_TIMEOUT
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire aca_axis_in_t ain,
	input wire logic master_cal,
	input wire logic power_dip,
	input wire logic run,
	input wire logic axis_sel,
	input wire aca_keys_t keys,
	output aca_axis_out_t aout
);
	// ----------------------------------------
	// per-axis state
	// ----------------------------------------
	logic [23:0] inc_ff, nxt_inc, abs_ff, nxt_abs, peak_ff, nxt_peak;
	logic spd_ff, nxt_spd, pf_ff, nxt_pf, rerr_ff, nxt_rerr;
	logic wait_ff, nxt_wait, sabs_ff, nxt_sabs, nc_ff, nxt_nc;
	logic [12:0] rcnt_ff, nxt_rcnt;
	logic err;
	logic rst_here;
	logic [23:0] inc_mv, abs_mv;
	logic ovf_inc, ovf_abs;

	assign err = spd_ff | pf_ff | rerr_ff | nc_ff;
	assign rst_here = keys.reset_cmd & axis_sel;
	// signed compare: a small negative position is still on the display
	assign ovf_inc = ($signed(inc_ff) > $signed(ACA_DISP_MAX)) || ($signed(inc_ff) < -$signed(ACA_DISP_MAX)); // R3
	assign ovf_abs = ($signed(abs_ff) > $signed(ACA_DISP_MAX)) || ($signed(abs_ff) < -$signed(ACA_DISP_MAX)); // R3

	always_comb begin
		nxt_inc = inc_ff;
		nxt_abs = abs_ff;
		nxt_peak = peak_ff;
		nxt_spd = spd_ff;
		nxt_pf = pf_ff;
		nxt_rerr = rerr_ff;
		nxt_wait = wait_ff;
		nxt_sabs = sabs_ff;
		nxt_nc = ~ain.unit_present; // R1
		nxt_rcnt = rcnt_ff;
		inc_mv = ain.step_neg ? inc_ff - ain.pos_step : inc_ff + ain.pos_step;
		abs_mv = ain.step_neg ? abs_ff - ain.pos_step : abs_ff + ain.pos_step;
		if (run && !err && !wait_ff && ain.pos_valid) begin
			nxt_inc = inc_mv;
			nxt_abs = abs_mv;
			if ($signed(inc_mv) > $signed(peak_ff))
				nxt_peak = inc_mv;
		end
		// set-vs-clear is handled below: set wins for overspeed and power fail, reset wins for ref error
		if (rst_here) begin // R13
			nxt_inc = ACA_RESET_VAL; // R8
			nxt_peak = ACA_RESET_VAL; // R8
			if (err || !run) begin
				nxt_abs = ACA_RESET_VAL; // R9
				nxt_wait = master_cal; // R7 R9
			end
			nxt_spd = 1'b0;
			nxt_pf = 1'b0;
			nxt_rerr = 1'b0;
			nxt_rcnt = '0;
		end else if (keys.start_cmd && axis_sel && run && !err && !wait_ff) begin
			nxt_peak = inc_ff; // R10
		end
		if (keys.absinc_cmd && axis_sel && run && !err)
			nxt_sabs = ~sabs_ff; // R11
		// a reset restarts the wait; a stale timeout count must not raise the error again
		if (wait_ff && run && !rst_here) begin
			if (ain.ref_pulse) begin
				nxt_wait = 1'b0;
				nxt_rcnt = '0;
			end else if (rcnt_ff == 13'(REF_TIMEOUT)) begin
				nxt_rerr = 1'b1; // R6
			end else begin
				nxt_rcnt = rcnt_ff + 13'h0001;
			end
		end
		if (run && ain.pos_valid && ain.pos_step > ACA_MAX_STEP)
			nxt_spd = 1'b1; // R2
		if (run && power_dip)
			nxt_pf = 1'b1; // R4
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			inc_ff <= ACA_RESET_VAL;
			abs_ff <= ACA_RESET_VAL;
			peak_ff <= ACA_RESET_VAL;
			spd_ff <= 1'b0;
			pf_ff <= 1'b0;
			rerr_ff <= 1'b0;
			wait_ff <= 1'b0;
			sabs_ff <= 1'b0;
			nc_ff <= 1'b0;
			rcnt_ff <= '0;
		end else begin
			inc_ff <= nxt_inc;
			abs_ff <= nxt_abs;
			peak_ff <= nxt_peak;
			spd_ff <= nxt_spd;
			pf_ff <= nxt_pf;
			rerr_ff <= nxt_rerr;
			wait_ff <= nxt_wait;
			sabs_ff <= nxt_sabs;
			nc_ff <= nxt_nc;
			rcnt_ff <= nxt_rcnt;
		end
	end

	always_comb begin
		aout.not_connected = nc_ff;
		aout.overspeed_indication = spd_ff;
		aout.power_fail = pf_ff;
		aout.ref_error = rerr_ff;
		aout.show_abs = sabs_ff;
		aout.waiting_ref = wait_ff;
		aout.incremental_value = inc_ff;
		aout.absolute_value = abs_ff;
		aout.peak_value = peak_ff;
		aout.overflow_digit = sabs_ff ? ovf_abs : ovf_inc; // R3
	end

	chk_spd_latch: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
		spd_ff && !rst_here |=> spd_ff) else $error("overspeed dropped without reset");
	chk_pf_latch: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
		pf_ff && !rst_here |=> pf_ff) else $error("power fail dropped without reset");
	chk_reset_inc: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
		rst_here && !err && run |=> inc_ff == ACA_RESET_VAL && peak_ff == ACA_RESET_VAL &&
		abs_ff == $past(abs_ff)) else $error("count reset wrong");
	chk_reset_err: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
		rst_here && err |=> abs_ff == ACA_RESET_VAL && wait_ff == $past(master_cal) && !rerr_ff)
		else $error("error reset wrong");
	chk_nc_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		!ain.unit_present |=> nc_ff) else $error("not connected missed");
	chk_absinc_blk: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
		!run |=> sabs_ff == $past(sabs_ff)) else $error("switch at power on");
	chk_start_peak: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		keys.start_cmd && axis_sel && run && !err && !wait_ff && !rst_here |=> peak_ff == $past(inc_ff))
		else $error("start did not restart peak");
	chk_start_blk: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		keys.start_cmd && !rst_here && (!run || err) |=> $stable(peak_ff))
		else $error("start acted while blocked");
endmodule : aca_axis

// ### hw/aca_top.sv
`timescale 1ns/1ps
module aca_top import aca_pkg::*; #(
	parameter int NAXES = 3,
	parameter int REF_TIMEOUT = ACA_REF_TIMEOUT,
	parameter logic [15:0] FW_VERSION = 16'h0100 // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire aca_axis_in_t [NAXES-1:0] axis_in,
	input wire logic power_dip_pin,
	input wire logic ext_reset_pin,
	input wire logic ext_start_pin,
	input wire aca_keys_t keys_in,
	input wire logic [NAXES-1:0] axis_select,
	input wire logic master_cal,
	input wire logic mem_corrupt,
	input wire logic [3:0] mem_code,
	output aca_axis_out_t [NAXES-1:0] axis_out,
	output logic [NAXES-1:0] axis_error,
	output logic show_version,
	output logic [15:0] version_value,
	output logic poweron_wait,
	output logic stored_data_error,
	output logic [3:0] stored_error_code
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] s1_ff, s2_ff;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s1_ff <= 3'h0;
			s2_ff <= 3'h0;
		end else begin
			s1_ff <= {power_dip_pin, ext_reset_pin, ext_start_pin};
			s2_ff <= s1_ff;
		end
	end

	// ----------------------------------------
	// display mode
	// ----------------------------------------
	aca_state_t st_ff, nxt_st;
	aca_keys_t k;
	logic run;
	logic sde_ff, nxt_sde;
	logic [3:0] code_ff, nxt_code;

	always_comb begin
		k = keys_in;
		k.reset_cmd = keys_in.reset_cmd | s2_ff[1];
		k.start_cmd = keys_in.start_cmd | s2_ff[0];
	end
	assign run = (st_ff == ACA_ST_COUNT);

	always_comb begin
		nxt_st = st_ff;
		nxt_sde = sde_ff;
		nxt_code = code_ff;
		case (st_ff)
			ACA_ST_POWERON: begin
				if (k.reset_cmd)
					nxt_st = ACA_ST_COUNT; // R7
				else if (keys_in.datum_key)
					nxt_st = ACA_ST_VERSION; // R12
			end
			ACA_ST_VERSION: begin
				if (keys_in != '0 || k.reset_cmd)
					nxt_st = ACA_ST_POWERON; // R12
			end
			ACA_ST_COUNT: nxt_st = ACA_ST_COUNT;
			default: nxt_st = ACA_ST_POWERON;
		endcase
		if (mem_corrupt && mem_code != ACA_CODE_NONE) begin
			nxt_sde = 1'b1; // R5
			nxt_code = mem_code; // R5
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_ff <= ACA_ST_POWERON;
			sde_ff <= 1'b0;
			code_ff <= ACA_CODE_NONE;
		end else begin
			st_ff <= nxt_st;
			sde_ff <= nxt_sde;
			code_ff <= nxt_code;
		end
	end

	// ----------------------------------------
	// axes
	// ----------------------------------------
	aca_axis_out_t [NAXES-1:0] ao;
	genvar g;
	generate
		for (g = 0; g < NAXES; g++) begin : g_ax
			aca_axis #(.REF_TIMEOUT(REF_TIMEOUT)) u_ax (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.ain(axis_in[g]),
				.master_cal(master_cal),
				.power_dip(s2_ff[2]),
				.run(run),
				.axis_sel(axis_select[g] | ~run),
				.keys(k),
				.aout(ao[g])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			axis_out <= '0;
			axis_error <= '0;
			show_version <= 1'b0;
			version_value <= 16'h0000;
			poweron_wait <= 1'b1;
			stored_data_error <= 1'b0;
			stored_error_code <= ACA_CODE_NONE;
		end else begin
			axis_out <= ao;
			for (int i = 0; i < NAXES; i++)
				axis_error[i] <= ao[i].not_connected | ao[i].overspeed_indication |
					ao[i].power_fail | ao[i].ref_error;
			show_version <= (st_ff == ACA_ST_VERSION);
			version_value <= FW_VERSION;
			poweron_wait <= (st_ff == ACA_ST_POWERON);
			stored_data_error <= sde_ff;
			stored_error_code <= code_ff;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence seq_back_to_wait;
		st_ff == ACA_ST_POWERON ##1 poweron_wait;
	endsequence

	chk_ver_entry: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		st_ff == ACA_ST_POWERON && keys_in.datum_key && !k.reset_cmd |=> st_ff == ACA_ST_VERSION)
		else $error("version not shown");
	chk_ver_exit: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		st_ff == ACA_ST_VERSION && keys_in.any_key |=> seq_back_to_wait)
		else $error("version exit wrong");
	chk_ver_any: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
		st_ff == ACA_ST_VERSION && keys_in != '0 |=> seq_back_to_wait)
		else $error("key did not leave version");
	chk_poweron_rst: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
		st_ff == ACA_ST_POWERON && k.reset_cmd |=> run) else $error("reset not starting");
	chk_sde_latch: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
		stored_data_error |=> stored_data_error) else $error("stored data error dropped");
	chk_code_range: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
		stored_data_error |-> stored_error_code != ACA_CODE_NONE)
		else $error("stored error code out of range");
endmodule : aca_top

// ### dv/aca_unit_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// measuring unit with reference mark
// ----------------------------------------
module aca_unit_model import aca_pkg::*; (
	input wire logic sys_clk,
	input wire logic present,
	input wire logic go,
	input wire logic [23:0] step,
	input wire logic neg,
	input wire logic ref_mark,
	output aca_axis_in_t ain
);
	initial ain = '0;
	always @(negedge sys_clk) begin
		ain.unit_present <= present;
		ain.pos_valid <= go & present;
		// idle step lines toggle so stale data never looks valid
		ain.pos_step <= go ? step : ~ain.pos_step;
		ain.step_neg <= neg;
		ain.ref_pulse <= ref_mark & present;
	end
endmodule : aca_unit_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import aca_pkg::*;
	localparam int NA = 2;
	localparam logic [15:0] VER = 16'h0A5C; // arbitrary value
	logic sys_clk = 0, nrst = 0, dip = 0, xrst = 0, xst = 0, mcal = 0, mcor = 0, neg = 0, sv, pw, sde;
	logic [3:0] mcode = 4'h0, sec;
	logic [NA-1:0] pres = '1, go = '0, sel = '1, refm = '0, aerr;
	logic [23:0] step = 24'h000000;
	logic [15:0] vv;
	aca_keys_t keys = '0;
	aca_axis_in_t [NA-1:0] ain;
	aca_axis_out_t [NA-1:0] aout;
	int miscompares = 0, n_tests = 0, inc = 0, absv = 0, pk = 0, w, big;
	always #2.5 sys_clk = ~sys_clk;
	for (genvar i = 0; i < NA; i++) begin : g_u
		aca_unit_model aca_unit_model_inst (.sys_clk(sys_clk), .present(pres[i]), .go(go[i]), .step(step),
			.neg(neg), .ref_mark(refm[i]), .ain(ain[i]));
	end
	aca_top #(.NAXES(NA), .REF_TIMEOUT(16), .FW_VERSION(VER)) aca_top_inst (.sys_clk(sys_clk), .nrst(nrst),
		.axis_in(ain), .power_dip_pin(dip), .ext_reset_pin(xrst), .ext_start_pin(xst), .keys_in(keys),
		.axis_select(sel), .master_cal(mcal), .mem_corrupt(mcor), .mem_code(mcode), .axis_out(aout),
		.axis_error(aerr), .show_version(sv), .version_value(vv), .poweron_wait(pw),
		.stored_data_error(sde), .stored_error_code(sec));
	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic key(aca_keys_t k);
		keys <= k;
		tick(1);
		keys <= '0;
		tick(5);
	endtask : key
	task automatic move(logic [1:0] ax, int s, bit n);
		step <= 24'(s);
		neg <= n;
		go <= ax;
		tick(1);
		go <= '0;
		tick(5);
		if (ax[0]) begin
			inc += n ? -s : s;
			absv += n ? -s : s;
			if (inc > pk) pk = inc;
		end
	endtask : move
	task automatic chkv();
		chk("vals", {aout[0].incremental_value, aout[0].absolute_value}, {24'(inc), 24'(absv)});
		chk("peak", aout[0].peak_value, 24'(pk));
	endtask : chkv
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(93258));
		tick(2);
		nrst <= 1;
		tick(3);
		chk("pwait", pw, 1'b1);
		key(5'b00100);
		chk("absinc", {pw, aout[0].show_abs}, 2'b10);
		key(5'b01000);
		chk("start", {pw, aout[0].peak_value}, {1'b1, 24'h0});
		key(5'b00010);
		chk("ver", {sv, vv}, {1'b1, VER});
		key(5'b00001);
		chk("back", {sv, pw}, 2'b01);
		key(5'b00010);
		key(5'b00010);
		chk("back2", {sv, pw}, 2'b01);
		key(5'b10000);
		chk("count", {pw, aout[0].waiting_ref}, 2'b00);
		chkv();
		key(5'b00100);
		chk("absinc_on", {aout[1].show_abs, aout[0].show_abs}, 2'b11);
		key(5'b00100);
		chk("absinc_off", aout[0].show_abs, 1'b0);
		repeat (6) move(2'b01, $urandom_range(16, 1), 0);
		move(2'b01, 3, 1);
		chkv();
		key(5'b01000);
		pk = inc;
		chkv();
		move(2'b01, 2, 1);
		xst <= 1;
		tick(1);
		xst <= 0;
		tick(6);
		pk = inc;
		chkv();
		move(2'b01, 2, 0);
		key(5'b10000);
		inc = 0;
		pk = 0;
		chkv();
		move(2'b01, 5, 1);
		chkv();
		big = $urandom_range(8388607, 1000000);
		move(2'b10, big, 0);
		chk("ovf", {aout[1].overflow_digit, aout[0].overflow_digit},
			{big > int'(ACA_DISP_MAX), inc > int'(ACA_DISP_MAX) || inc < -int'(ACA_DISP_MAX)});
		chk("spd", {aerr, aout[1].overspeed_indication, aout[0].overspeed_indication}, 4'b1010);
		tick(10);
		chk("spdhold", aout[1].overspeed_indication, 1'b1);
		sel <= 2'b10;
		key(5'b10000);
		chk("clr", {aout[1].overspeed_indication, aout[1].absolute_value, aout[0].absolute_value},
			{1'b0, 24'h0, 24'(absv)});
		sel <= '1;
		dip <= 1;
		tick(1);
		dip <= 0;
		tick(12);
		chk("pf", aout[0].power_fail, 1'b1);
		xrst <= 1;
		tick(1);
		xrst <= 0;
		tick(8);
		inc = 0;
		absv = 0;
		pk = 0;
		chk("pfclr", aout[0].power_fail, 1'b0);
		chkv();
		pres <= 2'b10;
		tick(5);
		chk("nc", {aout[1].not_connected, aout[0].not_connected}, 2'b01);
		pres <= '1;
		nrst <= 0;
		tick(2);
		nrst <= 1;
		tick(5);
		chk("recon", {aout[0].not_connected, aout[0].absolute_value}, {1'b0, 24'h0});
		mcor <= 1;
		mcode <= 4'hB;
		tick(5);
		chk("mem", {sde, sec}, {1'b1, 4'hB});
		mcal <= 1;
		key(5'b10000);
		chk("wref", aout[0].waiting_ref, 1'b1);
		for (w = 0; w < 100 && !aout[0].ref_error; w++) tick(1);
		chk("referr", aout[0].ref_error, 1'b1);
		if (w == 100) report_and_stop();
		key(5'b10000);
		chk("errrst", {aout[0].waiting_ref, aout[0].ref_error, aout[0].incremental_value}, {2'b10, 24'h0});
		refm <= 2'b01;
		tick(1);
		refm <= '0;
		tick(5);
		chk("refpass", {aout[1].waiting_ref, aout[0].waiting_ref}, 2'b10);
		report_and_stop();
	end
	initial begin
		tick(20000);
		miscompares++;
		report_and_stop();
	end
endmodule : testbench
